// ===== pkg/lane_detect_if.sv
// Carries the lane two termination mode and detect results between
// the register bank and the far receiver sequencer. Same clock domain.
interface lane_detect_if;
	repeater_cfg_pkg::term_mode_type mode;
	logic                            sense;
	logic                            present;
	logic                            term_50;
	logic                            probing;

	modport ctrl (output mode, output sense,
		input present, input term_50, input probing);
	modport det (input mode, input sense,
		output present, output term_50, output probing);
endinterface

// ===== pkg/repeater_cfg_pkg.sv
// Constants and types shared by the lane configuration register bank.
// Assumes a single 125 MHz clock domain and 8-bit SMBus registers.
package repeater_cfg_pkg;

	// Register offsets on the SMBus
	localparam logic [7:0] OFS_A1_DEEMPH    = 8'h35;
	localparam logic [7:0] OFS_A1_SQUELCH   = 8'h36;
	localparam logic [7:0] OFS_SPARE_A      = 8'h37;
	localparam logic [7:0] OFS_SPARE_B      = 8'h38;
	localparam logic [7:0] OFS_A2_MUTE_TERM = 8'h39;
	localparam logic [7:0] OFS_A2_EQ        = 8'h3a;
	localparam int         REG_COUNT        = 6;
	localparam logic [7:0] REG_END          = OFS_A1_DEEMPH + 8'(REG_COUNT);

	// Values after reset, in offset order
	localparam logic [7:0] REG_RESET [0:REG_COUNT-1] = '{
		8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h2f
	};

	// Writable bits of the mixed status register
	localparam logic [7:0] WMASK_A1_DEEMPH = 8'h1f;

	// Field positions
	localparam int PRESENT_BIT  = 7;
	localparam int RATE_HI      = 6;
	localparam int RATE_LO      = 5;
	localparam int DEEMPH_HI    = 2;
	localparam int DEEMPH_LO    = 0;
	localparam int ASSERT_HI    = 3;
	localparam int ASSERT_LO    = 2;
	localparam int DEASSERT_HI  = 1;
	localparam int DEASSERT_LO  = 0;
	localparam int OVERRIDE_BIT = 5;
	localparam int MUTE_BIT     = 4;
	localparam int TERM_HI      = 3;
	localparam int TERM_LO      = 2;

	// Receiver-detect timing
	localparam int CLK_PERIOD_NS        = 8;
	localparam int DETECT_PERIOD_MS     = 12;
	localparam int DETECT_SPAN_MS       = 600;
	localparam int DETECT_PERIOD_CYCLES =
		DETECT_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
	localparam int DETECT_ATTEMPTS      = DETECT_SPAN_MS / DETECT_PERIOD_MS;

	localparam logic [3:0] BYTE_BITS = 4'h8;

	typedef enum logic [1:0] {
		TERM_HIGH_Z         = 2'b00,
		TERM_DETECT_LIMITED = 2'b01,
		TERM_DETECT_ENDLESS = 2'b10,
		TERM_FIXED_50       = 2'b11
	} term_mode_type;

	typedef enum logic [6:0] {
		ST_IDLE = 7'b0000001,
		ST_ADDR = 7'b0000010,
		ST_OFFS = 7'b0000100,
		ST_WDAT = 7'b0001000,
		ST_ACK  = 7'b0010000,
		ST_RDAT = 7'b0100000,
		ST_RACK = 7'b1000000
	} smbus_state_type;

endpackage

// ===== verification/smbus_host_model.sv
// SMBus host model: bit-level master with an open-drain SDA pull-up.
// Assumes the device releases SDA by holding sda_oe_n high.
module smbus_host_model (
	input  wire logic mclk,
	input  wire logic sda_oe_n,
	output logic      scl,
	output logic      sda
);
	timeunit 1ns;
	timeprecision 100ps;
	logic host_low;
	// Pull-up: whichever party pulls low wins
	assign sda = !(host_low || !sda_oe_n);
	initial begin
		scl = 1'b1;
		host_low = 1'b0;
	end
	task automatic half();
		repeat (8) @(posedge mclk);
		#1;
	endtask
	// Data moves only well after SCL falls, never beside the edge
	task automatic send_bit(input logic b, output logic seen);
		repeat (2) @(posedge mclk);
		#1;
		host_low = !b;
		half();
		scl = 1'b1;
		half();
		seen = sda;
		scl = 1'b0;
	endtask
	task automatic start();
		half();
		host_low = 1'b0;
		half();
		scl = 1'b1;
		half();
		host_low = 1'b1;
		half();
		scl = 1'b0;
	endtask
	task automatic stop();
		half();
		host_low = 1'b1;
		half();
		scl = 1'b1;
		half();
		host_low = 1'b0;
		half();
	endtask
	task automatic send_byte(input logic [7:0] v, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			send_bit(v[i], s);
		end
		send_bit(1'b1, s);
		ack = !s;
	endtask
	task automatic get_byte(output logic [7:0] v);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			send_bit(1'b1, v[i]);
		end
		send_bit(1'b1, s);
	endtask
	// Callers pass zero in reserved bits and spare registers
	task automatic write_reg(input logic [6:0] a, input logic [7:0] o,
		input logic [7:0] d, output logic ack);
		logic a1, a2, a3;
		start();
		send_byte({a, 1'b0}, a1);
		send_byte(o, a2);
		send_byte(d, a3);
		stop();
		ack = a1 & a2 & a3;
	endtask
	task automatic read_reg(input logic [6:0] a, input logic [7:0] o,
		output logic [7:0] d, output logic ack);
		logic a1, a2, a3;
		start();
		send_byte({a, 1'b0}, a1);
		send_byte(o, a2);
		start();
		send_byte({a, 1'b1}, a3);
		get_byte(d);
		stop();
		ack = a1 & a2 & a3;
	endtask
endmodule

// ===== verification/testbench.sv
// Self-checking bench for the lane configuration register bank.
// Assumes the host model owns SCL and resolves the SDA wire.
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [6:0] ADDR   = 7'h2c;
	localparam int         PERIOD = 20;
	logic       mclk, arst_n, scl, sda, sda_out, sda_oe_n, mode_strap;
	logic [1:0] sd_strap, rx_strap, rate, thr_a, thr_d;
	logic       present_a1, idle, sense, mute, term, probe, present;
	logic [2:0] deemph;
	logic [7:0] eq;
	int         fails, comparisons;
	repeater_lane_config_regs #(.SLAVE_ADDR(ADDR),
		.DETECT_PERIOD_CYCLES(PERIOD)) dut (
		.mclk(mclk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n),
		.register_mode_strap(mode_strap),
		.signal_detect_level_strap(sd_strap),
		.far_receiver_sense_strap(rx_strap),
		.lane_a1_receiver_present_flag(present_a1),
		.lane_a1_detected_rate_field(rate), .lane_a2_input_idle(idle),
		.lane_a2_far_receiver_sense(sense),
		.lane_a1_output_deemphasis_setting(deemph),
		.lane_a1_assert_threshold(thr_a),
		.lane_a1_deassert_threshold(thr_d),
		.lane_a2_output_mute(mute), .lane_a2_input_termination_50(term),
		.lane_a2_far_receiver_probe(probe),
		.lane_a2_receiver_present(present),
		.lane_a2_input_equalizer_level(eq));
	smbus_host_model host (.mclk(mclk), .sda_oe_n(sda_oe_n), .scl(scl),
		.sda(sda));
	task automatic chk(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic wr(input logic [7:0] o, input logic [7:0] d);
		logic ack;
		host.write_reg(ADDR, o, d, ack);
		chk("write ack", 8'h01, 8'(ack));
	endtask
	task automatic rd_chk(input logic [7:0] o, input logic [7:0] exp);
		logic [7:0] d;
		logic       ack;
		host.read_reg(ADDR, o, d, ack);
		chk("read ack", 8'h01, 8'(ack));
		chk($sformatf("reg %h", o), exp, d);
	endtask
	task automatic reset_values();
		chk("deemph", 8'h02, 8'(deemph));
		chk("eq", 8'h2f, eq);
		chk("thresholds", 8'h00, 8'({thr_a, thr_d}));
		chk("lane two", 8'h00, 8'({mute, term, probe, present}));
		chk("bus idle", 8'h01, 8'({sda_out, sda_oe_n}));
		for (int i = 0; i < repeater_cfg_pkg::REG_COUNT; i++) begin
			rd_chk(repeater_cfg_pkg::OFS_A1_DEEMPH + 8'(i),
				repeater_cfg_pkg::REG_RESET[i]);
		end
	endtask
	task automatic status_bits();
		present_a1 = 1'b1;
		rate = 2'b01;
		wr(8'h35, 8'h45);
		rd_chk(8'h35, 8'ha5);
		present_a1 = 1'b0;
		rate = 2'b11;
		cyc(8);
		rd_chk(8'h35, 8'h65);
		for (int c = 0; c < 8; c++) begin
			wr(8'h35, 8'(c));
			chk("deemph code", 8'(c), 8'(deemph));
		end
	endtask
	task automatic thresholds();
		wr(8'h36, 8'h0e);
		chk("assert thr", 8'h03, 8'(thr_a));
		chk("deassert thr", 8'h02, 8'(thr_d));
		sd_strap = 2'b01;
		cyc(8);
		chk("thr over strap", 8'h0e, 8'({thr_a, thr_d}));
		mode_strap = 1'b0;
		cyc(8);
		chk("strap thr", 8'h05, 8'({thr_a, thr_d}));
		mode_strap = 1'b1;
		cyc(8);
	endtask
	task automatic mute_control();
		wr(8'h39, 8'h30);
		chk("forced mute", 8'h01, 8'(mute));
		idle = 1'b1;
		wr(8'h39, 8'h20);
		chk("forced on", 8'h00, 8'(mute));
		wr(8'h39, 8'h00);
		chk("auto mute", 8'h01, 8'(mute));
		idle = 1'b0;
		cyc(10);
		chk("auto on", 8'h00, 8'(mute));
	endtask
	task automatic fixed_modes();
		wr(8'h39, 8'h0c);
		chk("fixed 50", 8'h02, 8'({term, probe}));
		rx_strap = 2'b11;
		wr(8'h39, 8'h00);
		chk("high z", 8'h00, 8'({term, probe}));
		mode_strap = 1'b0;
		cyc(8);
		chk("strap mode", 8'h02, 8'({term, probe}));
		mode_strap = 1'b1;
		cyc(8);
	endtask
	task automatic detect_modes();
		wr(8'h39, 8'h08);
		cyc(5 * PERIOD);
		chk("endless probing", 8'h02, 8'({present, probe, term}));
		sense = 1'b1;
		cyc(3 * PERIOD);
		chk("found", 8'h05, 8'({present, probe, term}));
		sense = 1'b0;
		wr(8'h39, 8'h04);
		cyc(45 * PERIOD);
		chk("limited probing", 8'h02, 8'({present, probe, term}));
		cyc(10 * PERIOD);
		chk("gave up", 8'h00, 8'({present, probe, term}));
		sense = 1'b1;
		cyc(3 * PERIOD);
		chk("no late find", 8'h00, 8'({present, probe, term}));
	endtask
	task automatic bus_edges();
		logic ack;
		wr(8'h3a, 8'hff);
		chk("eq", 8'hff, eq);
		rd_chk(8'h3a, 8'hff);
		wr(8'h3a, 8'h00);
		chk("eq", 8'h00, eq);
		rd_chk(8'h50, 8'h00);
		host.write_reg(7'h2d, 8'h3a, 8'h11, ack);
		chk("foreign ack", 8'h00, 8'(ack));
		chk("eq kept", 8'h00, eq);
	endtask
	task automatic complete_run();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	initial begin
		repeat (80000) @(posedge mclk);
		fails++;
		complete_run();
	end
	initial begin
		arst_n = 1'b0;
		mode_strap = 1'b1;
		sd_strap = 2'b00;
		rx_strap = 2'b00;
		present_a1 = 1'b0;
		rate = 2'b00;
		idle = 1'b0;
		sense = 1'b0;
		cyc(5);
		arst_n = 1'b1;
		cyc(6);
		reset_values();
		status_bits();
		thresholds();
		mute_control();
		fixed_modes();
		detect_modes();
		bus_edges();
		// Reset again in mid-run: everything must return to defaults
		arst_n = 1'b0;
		sense = 1'b0;
		rate = 2'b00;
		cyc(5);
		arst_n = 1'b1;
		cyc(6);
		reset_values();
		complete_run();
	end
endmodule

// ===== verilog/far_receiver_sequencer.sv
// Lane two far receiver detection and input termination sequencing.
// Assumes the sense input is already synchronised to mclk.
module far_receiver_sequencer #(
	parameter int unsigned PERIOD_CYCLES = repeater_cfg_pkg::DETECT_PERIOD_CYCLES,
	parameter int unsigned ATTEMPTS      = repeater_cfg_pkg::DETECT_ATTEMPTS
) (
	input wire logic    mclk,
	input wire logic    arst_n,
	lane_detect_if.det  link
);
	logic [31:0]                     tick_count;
	logic [7:0]                      tries;
	repeater_cfg_pkg::term_mode_type mode_q;
	logic                            present;
	logic                            restart;
	logic                            auto_mode;
	logic                            tick;
	logic                            exhausted;
	logic                            probing;

	if (PERIOD_CYCLES < 2 || ATTEMPTS < 1 || ATTEMPTS > 255) begin : g_bad
		$error("far_receiver_sequencer: unsupported period or attempts");
	end

	assign restart   = link.mode != mode_q;
	assign auto_mode = link.mode == repeater_cfg_pkg::TERM_DETECT_LIMITED
		|| link.mode == repeater_cfg_pkg::TERM_DETECT_ENDLESS;
	assign tick      = tick_count == 32'(PERIOD_CYCLES - 1);
	assign exhausted = link.mode == repeater_cfg_pkg::TERM_DETECT_LIMITED
		&& tries == 8'(ATTEMPTS); // R11
	assign probing   = auto_mode && !present && !exhausted && !restart; // R12

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			mode_q <= repeater_cfg_pkg::TERM_HIGH_Z;
		end else begin
			mode_q <= link.mode;
		end
	end

	// One attempt per period while probing
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			tick_count <= '0;
		end else if (!probing || tick) begin
			tick_count <= '0;
		end else begin
			tick_count <= tick_count + 32'h1;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			tries <= '0;
		end else if (restart) begin
			tries <= '0;
		end else if (probing && tick) begin
			tries <= tries + 8'h1; // R11
		end
	end

	// A new mode starts detection over
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			present <= 1'b0;
		end else if (restart || !auto_mode) begin
			present <= 1'b0;
		end else if (probing && tick && link.sense) begin
			present <= 1'b1;
		end
	end

	assign link.present = present;
	assign link.probing = probing;
	assign link.term_50 = link.mode == repeater_cfg_pkg::TERM_FIXED_50
		|| (auto_mode && present); // R10 R13

	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);

	a_attempt_cap: assert property ( // R11
		link.mode == repeater_cfg_pkg::TERM_DETECT_LIMITED && !restart
		|-> tries <= 8'(ATTEMPTS) && (tries != 8'(ATTEMPTS) || !probing))
		else $error("limited detect ran past its attempt count");
	a_endless_retry: assert property ( // R12
		link.mode == repeater_cfg_pkg::TERM_DETECT_ENDLESS
		&& $stable(link.mode) && !present |-> probing)
		else $error("endless detect stopped before a receiver was found");
	a_hiz_until: assert property ( // R13
		auto_mode && !present |-> !link.term_50)
		else $error("termination applied before detection");
	a_term_fixed: assert property ( // R10
		link.mode == repeater_cfg_pkg::TERM_HIGH_Z |-> !link.term_50
		&& !probing)
		else $error("high impedance mode terminated or probed");
endmodule

// ===== verilog/pin_sync.sv
// Three-stage synchroniser for pins; a change is taken once the second
// and third stages agree. Assumes asynchronous inputs, one clock.
module pin_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             mclk,
	input  wire logic             arst_n,
	input  wire logic [WIDTH-1:0] pin,
	output logic      [WIDTH-1:0] filtered
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;

	if (WIDTH < 1) begin : g_bad_width
		$error("pin_sync: WIDTH must be at least one");
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
		end else begin
			stage1 <= pin;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// Per bit: follow only when the two later stages agree
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			filtered <= '0;
		end else begin
			filtered <= (stage2 & stage3) | (filtered & (stage2 ^ stage3));
		end
	end
endmodule

// ===== verilog/repeater_lane_config_regs.sv
// Lane configuration register bank behind an SMBus slave, with the
// lane one status and de-emphasis, squelch thresholds, lane two mute,
// termination and equalizer controls.
// Assumes one 125 MHz clock; all pins arrive asynchronously.

// Notes on behaviour
// R1: Bit 7 shows lane receiver present, read-only.
// R2: Bits 6:5 show detected rate, read-only.
// R3: Bits 2:0 select de-emphasis, default code 010.
// R4: Bits 3:2 select assert threshold, default 00.
// R5: Bits 1:0 select deassert threshold, default 00.
// R6: Register thresholds override the threshold strap.
// R7: Override bit 5 set obeys mute bit 4.
// R8: Override clear mutes from own idle detection.
// R9: Mute bit 1 idles output, 0 enables.
// R10: Mode 00 high impedance, 11 fixed 50 ohm.
// R11: Mode 01 probes every 12 ms, 50 times.
// R12: Mode 10 probes every 12 ms until found.
// R13: Auto modes terminate only after detection.
// R14: Register termination mode overrides detect strap.
// R15: Equalizer is full byte, reset 0x2f.
// R16: Status bits ignore writes, show live results.
// R17: Host writes zero to reserved and spares.
module repeater_lane_config_regs #(
	parameter logic [6:0]  SLAVE_ADDR           = 7'h2c,
	parameter int unsigned DETECT_PERIOD_CYCLES =
		repeater_cfg_pkg::DETECT_PERIOD_CYCLES
) (
	input  wire logic mclk,
	input  wire logic arst_n,
	input  wire logic scl_in,
	input  wire logic sda_in,
	output logic      sda_out,
	output logic      sda_oe_n,
	input  wire logic register_mode_strap,
	input  wire logic [1:0] signal_detect_level_strap,
	input  wire logic [1:0] far_receiver_sense_strap,
	input  wire logic lane_a1_receiver_present_flag,
	input  wire logic [1:0] lane_a1_detected_rate_field,
	input  wire logic lane_a2_input_idle,
	input  wire logic lane_a2_far_receiver_sense,
	output logic [2:0] lane_a1_output_deemphasis_setting,
	output logic [1:0] lane_a1_assert_threshold,
	output logic [1:0] lane_a1_deassert_threshold,
	output logic      lane_a2_output_mute,
	output logic      lane_a2_input_termination_50,
	output logic      lane_a2_far_receiver_probe,
	output logic      lane_a2_receiver_present,
	output logic [7:0] lane_a2_input_equalizer_level
);
	logic [11:0]                       pins_s;
	logic                              scl_f;
	logic                              sda_f;
	logic                              reg_mode_s;
	logic [1:0]                        sd_strap_s;
	logic [1:0]                        rx_strap_s;
	logic                              a1_present_s;
	logic [1:0]                        a1_rate_s;
	logic                              a2_idle_s;
	logic                              scl_q;
	logic                              sda_q;
	logic                              scl_rise;
	logic                              scl_fall;
	logic                              start_seen;
	logic                              stop_seen;
	repeater_cfg_pkg::smbus_state_type state;
	repeater_cfg_pkg::smbus_state_type after_ack;
	logic [7:0]                        shift;
	logic [3:0]                        bit_count;
	logic [7:0]                        offset;
	logic                              wr_pulse;
	logic [7:0]                        wr_ofs;
	logic [7:0]                        wr_data;
	logic [7:0]                        read_byte;
	logic [7:0]                        regs [0:repeater_cfg_pkg::REG_COUNT-1];

	lane_detect_if detect_link ();

	if (SLAVE_ADDR == 7'h00) begin : g_bad_addr
		$error("repeater_lane_config_regs: address 0 is the general call");
	end

	function automatic logic hits(input logic [7:0] ofs);
		return ofs >= repeater_cfg_pkg::OFS_A1_DEEMPH
			&& ofs < repeater_cfg_pkg::REG_END;
	endfunction

	function automatic logic [2:0] slot(input logic [7:0] ofs);
		logic [7:0] diff;
		diff = ofs - repeater_cfg_pkg::OFS_A1_DEEMPH;
		return diff[2:0];
	endfunction

	pin_sync #(
		.WIDTH (12)
	) u_pin_sync (
		.mclk     (mclk),
		.arst_n   (arst_n),
		.pin      ({scl_in, sda_in, register_mode_strap,
			signal_detect_level_strap, far_receiver_sense_strap,
			lane_a1_receiver_present_flag, lane_a1_detected_rate_field,
			lane_a2_input_idle, lane_a2_far_receiver_sense}),
		.filtered (pins_s)
	);

	assign scl_f        = pins_s[11];
	assign sda_f        = pins_s[10];
	assign reg_mode_s   = pins_s[9];
	assign sd_strap_s   = pins_s[8:7];
	assign rx_strap_s   = pins_s[6:5];
	assign a1_present_s = pins_s[4];
	assign a1_rate_s    = pins_s[3:2];
	assign a2_idle_s    = pins_s[1];
	assign detect_link.sense = pins_s[0];

	far_receiver_sequencer #(
		.PERIOD_CYCLES (DETECT_PERIOD_CYCLES),
		.ATTEMPTS      (repeater_cfg_pkg::DETECT_ATTEMPTS)
	) u_far_receiver_sequencer (
		.mclk   (mclk),
		.arst_n (arst_n),
		.link   (detect_link.det)
	);

	// Bus edges and start or stop conditions
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_f;
			sda_q <= sda_f;
		end
	end

	assign scl_rise   = scl_f && !scl_q;
	assign scl_fall   = !scl_f && scl_q;
	assign start_seen = scl_f && scl_q && sda_q && !sda_f;
	assign stop_seen  = scl_f && scl_q && !sda_q && sda_f;

	// Status bits are live; only the low field is stored
	always_comb begin
		read_byte = 8'h00;
		if (hits(offset)) begin
			read_byte = regs[slot(offset)];
			if (offset == repeater_cfg_pkg::OFS_A1_DEEMPH) begin
				read_byte = {a1_present_s, a1_rate_s, // R1 R2 R16
					regs[slot(offset)][4:0]};
			end
		end
	end

	// SMBus byte engine: write and read byte, offset auto-increments
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state     <= repeater_cfg_pkg::ST_IDLE;
			after_ack <= repeater_cfg_pkg::ST_IDLE;
			shift     <= 8'h00;
			bit_count <= 4'h0;
			offset    <= 8'h00;
			wr_pulse  <= 1'b0;
			wr_ofs    <= 8'h00;
			wr_data   <= 8'h00;
			sda_oe_n  <= 1'b1;
		end else begin
			wr_pulse <= 1'b0;
			if (start_seen) begin
				state     <= repeater_cfg_pkg::ST_ADDR;
				bit_count <= 4'h0;
				sda_oe_n  <= 1'b1;
			end else if (stop_seen) begin
				state    <= repeater_cfg_pkg::ST_IDLE;
				sda_oe_n <= 1'b1;
			end else begin
				case (state)
				repeater_cfg_pkg::ST_ADDR,
				repeater_cfg_pkg::ST_OFFS,
				repeater_cfg_pkg::ST_WDAT: begin
					if (scl_rise) begin
						shift     <= {shift[6:0], sda_f};
						bit_count <= bit_count + 4'h1;
					end else if (scl_fall
						&& bit_count == repeater_cfg_pkg::BYTE_BITS) begin
						bit_count <= 4'h0;
						if (state == repeater_cfg_pkg::ST_ADDR) begin
							if (shift[7:1] == SLAVE_ADDR) begin
								state     <= repeater_cfg_pkg::ST_ACK;
								sda_oe_n  <= 1'b0;
								after_ack <= shift[0]
									? repeater_cfg_pkg::ST_RDAT
									: repeater_cfg_pkg::ST_OFFS;
							end else begin
								state <= repeater_cfg_pkg::ST_IDLE;
							end
						end else begin
							state     <= repeater_cfg_pkg::ST_ACK;
							sda_oe_n  <= 1'b0;
							after_ack <= repeater_cfg_pkg::ST_WDAT;
							if (state == repeater_cfg_pkg::ST_OFFS) begin
								offset <= shift;
							end else begin
								wr_pulse <= 1'b1;
								wr_ofs   <= offset;
								wr_data  <= shift;
								offset   <= offset + 8'h01;
							end
						end
					end
				end
				repeater_cfg_pkg::ST_ACK: begin
					if (scl_fall) begin
						state <= after_ack;
						if (after_ack == repeater_cfg_pkg::ST_RDAT) begin
							shift    <= read_byte;
							sda_oe_n <= read_byte[7];
							offset   <= offset + 8'h01;
						end else begin
							sda_oe_n <= 1'b1;
						end
					end
				end
				repeater_cfg_pkg::ST_RDAT: begin
					if (scl_rise) begin
						bit_count <= bit_count + 4'h1;
					end else if (scl_fall) begin
						if (bit_count == repeater_cfg_pkg::BYTE_BITS) begin
							bit_count <= 4'h0;
							sda_oe_n  <= 1'b1;
							state     <= repeater_cfg_pkg::ST_RACK;
						end else begin
							shift    <= {shift[6:0], 1'b0};
							sda_oe_n <= shift[6];
						end
					end
				end
				repeater_cfg_pkg::ST_RACK: begin
					// Host ack fetches the next byte; nack ends the read
					if (scl_rise) begin
						state     <= sda_f ? repeater_cfg_pkg::ST_IDLE
							: repeater_cfg_pkg::ST_ACK;
						after_ack <= repeater_cfg_pkg::ST_RDAT;
					end
				end
				default: begin
					state <= repeater_cfg_pkg::ST_IDLE;
				end
				endcase
			end
		end
	end

	// Register storage; unmapped offsets ignore writes
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < repeater_cfg_pkg::REG_COUNT; i++) begin
				regs[i] <= repeater_cfg_pkg::REG_RESET[i]; // R3 R4 R5 R15
			end
		end else if (wr_pulse && hits(wr_ofs)) begin
			if (wr_ofs == repeater_cfg_pkg::OFS_A1_DEEMPH) begin
				regs[slot(wr_ofs)] <= wr_data
					& repeater_cfg_pkg::WMASK_A1_DEEMPH; // R16
			end else begin
				regs[slot(wr_ofs)] <= wr_data;
			end
		end
	end

	// Lane controls; register mode takes precedence over the straps
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			lane_a1_output_deemphasis_setting <= 3'h2;
			lane_a1_assert_threshold          <= 2'h0;
			lane_a1_deassert_threshold        <= 2'h0;
			lane_a2_input_equalizer_level     <= 8'h2f;
			detect_link.mode <= repeater_cfg_pkg::TERM_HIGH_Z;
		end else begin
			lane_a1_output_deemphasis_setting <= regs[0][2:0]; // R3
			lane_a2_input_equalizer_level     <= regs[5]; // R15
			if (reg_mode_s) begin
				lane_a1_assert_threshold   <= regs[1][3:2]; // R4 R6
				lane_a1_deassert_threshold <= regs[1][1:0]; // R5 R6
				detect_link.mode <= repeater_cfg_pkg::term_mode_type'(
					regs[4][3:2]); // R14
			end else begin
				lane_a1_assert_threshold   <= sd_strap_s;
				lane_a1_deassert_threshold <= sd_strap_s;
				detect_link.mode <= repeater_cfg_pkg::term_mode_type'(
					rx_strap_s);
			end
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			lane_a2_output_mute          <= 1'b0;
			lane_a2_input_termination_50 <= 1'b0;
			lane_a2_far_receiver_probe   <= 1'b0;
			lane_a2_receiver_present     <= 1'b0;
			sda_out                      <= 1'b0;
		end else begin
			lane_a2_output_mute <= regs[4][5] ? regs[4][4] // R7 R9
				: a2_idle_s; // R8
			lane_a2_input_termination_50 <= detect_link.term_50; // R10 R13
			lane_a2_far_receiver_probe   <= detect_link.probing;
			lane_a2_receiver_present     <= detect_link.present;
			sda_out                      <= 1'b0;
		end
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);

	sequence s_eq_write;
		wr_pulse && wr_ofs == repeater_cfg_pkg::OFS_A2_EQ;
	endsequence

	a_present_bit: assert property ( // R1
		offset == repeater_cfg_pkg::OFS_A1_DEEMPH
		|-> read_byte[7] == a1_present_s)
		else $error("receiver present bit does not show status");
	a_rate_field: assert property ( // R2
		offset == repeater_cfg_pkg::OFS_A1_DEEMPH
		|-> read_byte[6:5] == a1_rate_s)
		else $error("rate field does not show status");
	a_deemph_follow: assert property ( // R3
		wr_pulse && wr_ofs == repeater_cfg_pkg::OFS_A1_DEEMPH
		|-> ##2 lane_a1_output_deemphasis_setting == $past(wr_data[2:0], 2))
		else $error("de-emphasis output missed a write");
	a_thresh_reg: assert property ( // R4 R5 R6
		reg_mode_s |=> lane_a1_assert_threshold == $past(regs[1][3:2])
		&& lane_a1_deassert_threshold == $past(regs[1][1:0]))
		else $error("register thresholds not applied");
	a_mute_manual: assert property ( // R7 R9
		regs[4][5] |=> lane_a2_output_mute == $past(regs[4][4]))
		else $error("manual mute not obeyed");
	a_mute_auto: assert property ( // R8
		!regs[4][5] |=> lane_a2_output_mute == $past(a2_idle_s))
		else $error("automatic mute does not follow idle detect");
	a_far_receiver_sense_reg: assert property ( // R14
		reg_mode_s |=> detect_link.mode == $past(regs[4][3:2]))
		else $error("termination strap overrode the register");
	a_ro_ignored: assert property ( // R16
		wr_pulse && wr_ofs == repeater_cfg_pkg::OFS_A1_DEEMPH
		|=> regs[0][7:5] == 3'h0)
		else $error("read-only status bits were stored");
	a_eq_write: assert property ( // R15
		s_eq_write |-> ##2 lane_a2_input_equalizer_level == $past(wr_data, 2))
		else $error("equalizer level missed a write");
endmodule
